// ==== verilog/tx_pcs_channel.sv ====
// Transmit PCS channel: phase FIFO, byte serializer, 8b/10b stage, AXI4-Lite.
// Function
// - FIFO overflow or underflow drives the phase FIFO error output high.
// - Low-latency mode: four-word FIFO, two to three cycles of latency.
// - High-latency mode: eight-word FIFO, four to five cycles of latency.
// - Both FIFO sides run on the one clock aclk in every configuration.
// - Enabled byte serializer halves the datapath width.
// - Serializer sends the low half first, then the high half.
// - Double width: bits 19 to 0 first, then bits 39 to 20.
// - Transmit digital reset resets the byte serializer.
// - Serializer output goes to the encoder if enabled, else straight out.
// - Each byte with control flag becomes one 10-bit group with disparity.
// - Control flag high gives a K group, low a D group; LSB first.
// - During single-width reset: clear state, ignore input, send K28.5-.
// - After single-width reset: start negative, send three K28.5 groups.
// - Pipeline words may precede the first synchronizing K28.5.
// - Double width: two cascaded encoders, low byte sent first.
// - Double width: control bit 0 marks low byte, bit 1 high byte.
// - During double-width reset: K28.5- low byte, K28.5+ high byte.
// - After double-width reset: low negative, high positive, three each.
// - Forced disparity: value 0 encodes positive, 1 negative.
// - Low-latency PCS option bypasses the encoder.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pcs_regs.svh"
module tx_pcs_channel
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_digitalreset,
  input wire logic tx_wr_en,
  input wire logic [39:0] tx_datain,
  input wire logic [3:0] tx_ctrlenable,
  input wire logic [3:0] tx_forcedisp,
  input wire logic [3:0] tx_dispval,
  output logic [19:0] tx_dataout,
  output logic tx_dataout_valid,
  output logic tx_phase_comp_fifo_error
);
  import tx_pcs_pkg::*;

  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [3:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0] ctrl_reg, ctrl_next;
  logic err_reg, err_next;
  logic do_write;

  logic dig_clr, double_w, ser_en, enc_on, hilat;
  word_t in_word, rd_data, hold_reg, hold_next;
  level_t level, start_level;
  logic full, empty, rd_en, need_word, fifo_event;
  logic started_reg, started_next;
  logic phase_reg, phase_next;
  logic [25:0] pair;
  logic emit_data;
  enc_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic sync_emit, run_emit;
  logic [7:0] a_byte, b_byte;
  logic a_k, b_k, a_rd, b_rd, a_rd_out, b_rd_out;
  logic [9:0] a_code, b_code;
  logic [19:0] dout_reg, dout_next;
  logic dvalid_reg, dvalid_next;

  // Register bus: write and read channels.
  always_comb
  begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    if (do_write)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == `CTRL_OFFSET ||
        awaddr_reg == `STATUS_OFFSET) ? `AXI_OKAY : `AXI_SLVERR;
    end
    if (s_axi_awvalid && awready_reg)
    begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = `AXI_OKAY;
      unique case (s_axi_araddr)
        `CTRL_OFFSET: rdata_next = {27'h000_0000, ctrl_reg};
        `STATUS_OFFSET: rdata_next = {24'h00_0000, level, 2'h0,
          state_reg != ENC_RUN, err_reg};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = `AXI_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
    ctrl_next = ctrl_reg;
    if (do_write && awaddr_reg == `CTRL_OFFSET && wstrb_reg[0])
    begin
      ctrl_next = wdata_reg[4:0];
    end
    err_next = err_reg;
    if (do_write && awaddr_reg == `STATUS_OFFSET && wstrb_reg[0] &&
      wdata_reg[`STAT_ERR_BIT])
    begin
      err_next = 1'b0;
    end
    if (fifo_event)
    begin
      err_next = 1'b1;
    end
    if (dig_clr)
    begin
      err_next = 1'b0;
    end
    if (!aresetn)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      awready_next = 1'b0;
      wready_next = 1'b0;
      bvalid_next = 1'b0;
      bresp_next = `AXI_OKAY;
      arready_next = 1'b0;
      rvalid_next = 1'b0;
      rresp_next = `AXI_OKAY;
      rdata_next = 32'h0000_0000;
      ctrl_next = `CTRL_RESET;
    end
  end

  always_ff @(posedge aclk)
  begin
    aw_have_reg <= aw_have_next;
    w_have_reg <= w_have_next;
    awaddr_reg <= awaddr_next;
    wdata_reg <= wdata_next;
    wstrb_reg <= wstrb_next;
    awready_reg <= awready_next;
    wready_reg <= wready_next;
    bvalid_reg <= bvalid_next;
    bresp_reg <= bresp_next;
    arready_reg <= arready_next;
    rvalid_reg <= rvalid_next;
    rresp_reg <= rresp_next;
    rdata_reg <= rdata_next;
    ctrl_reg <= ctrl_next;
    err_reg <= err_next;
  end

  // Phase FIFO fill, drain and serializer half selection.
  always_comb
  begin
    dig_clr = !aresetn || tx_digitalreset;
    double_w = ctrl_reg[`CTRL_DOUBLE_BIT];
    ser_en = ctrl_reg[`CTRL_SER_BIT];
    hilat = ctrl_reg[`CTRL_HILAT_BIT];
    enc_on = ctrl_reg[`CTRL_ENC_BIT] && !ctrl_reg[`CTRL_LLPCS_BIT];
    for (int i = 0; i < 4; i++)
    begin
      in_word[i*`LANE_W +: `LANE_W] = {tx_dispval[i], tx_forcedisp[i],
        tx_ctrlenable[i], tx_datain[i*10 +: 10]};
    end
    start_level = hilat ? `FIFO_START_HIGH : `FIFO_START_LOW;
    need_word = started_reg && (!ser_en || !phase_reg);
    rd_en = need_word && !empty;
    fifo_event = (need_word && empty) || (tx_wr_en && full && !rd_en);
    started_next = started_reg ||
      (state_reg == ENC_RUN && level >= start_level);
    phase_next = ser_en && !phase_reg && rd_en;
    hold_next = rd_en ? rd_data : hold_reg;
    if (phase_reg)
    begin
      pair = double_w ? hold_reg[51:26] : {13'h0000, hold_reg[25:13]};
    end
    else
    begin
      pair = rd_data[25:0];
    end
    emit_data = rd_en || phase_reg;
    if (dig_clr)
    begin
      started_next = 1'b0;
      phase_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    started_reg <= started_next;
    phase_reg <= phase_next;
    hold_reg <= hold_next;
  end

  // Single clock serves both FIFO sides in every configuration.
  tx_phase_fifo u_fifo
  (
    .aclk(aclk),
    .clear(dig_clr),
    .high_latency(hilat),
    .wr_en(tx_wr_en),
    .wr_data(in_word),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .level(level),
    .full(full),
    .empty(empty)
  );

  // Encoder lane inputs, sync sequence and disparity state.
  always_comb
  begin
    sync_emit = !dig_clr && state_reg != ENC_RUN;
    run_emit = !dig_clr && state_reg == ENC_RUN && emit_data;
    a_byte = pair[7:0];
    a_k = pair[`LANE_CTRL_BIT];
    a_rd = pair[`LANE_FORCE_BIT] ? !pair[`LANE_DVAL_BIT] : rd_reg;
    b_byte = pair[`LANE_W+7:`LANE_W];
    b_k = pair[`LANE_W+`LANE_CTRL_BIT];
    b_rd = pair[`LANE_W+`LANE_FORCE_BIT] ?
      !pair[`LANE_W+`LANE_DVAL_BIT] : a_rd_out;
    if (dig_clr || state_reg != ENC_RUN)
    begin
      a_byte = `K28_5;
      a_k = 1'b1;
      a_rd = dig_clr ? 1'b0 : rd_reg;
      b_byte = `K28_5;
      b_k = 1'b1;
      b_rd = a_rd_out;
    end
    state_next = state_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    if (sync_emit || run_emit)
    begin
      rd_next = double_w ? b_rd_out : a_rd_out;
    end
    if (sync_emit)
    begin
      cnt_next = cnt_reg + 2'h1;
      state_next = (cnt_reg == `SYNC_GROUPS - 2'h1) ? ENC_RUN : ENC_SYNC;
    end
    if (dig_clr)
    begin
      state_next = ENC_RESET;
      cnt_next = 2'h0;
      rd_next = 1'b0;
    end
    dout_next = dout_reg;
    dvalid_next = 1'b0;
    if (enc_on)
    begin
      if (dig_clr || sync_emit || run_emit)
      begin
        dout_next = {double_w ? b_code : 10'h000, a_code};
        dvalid_next = 1'b1;
      end
    end
    else if (run_emit)
    begin
      dout_next = {double_w ? pair[`LANE_W+9:`LANE_W] : 10'h000,
        pair[9:0]};
      dvalid_next = 1'b1;
    end
    else if (dig_clr)
    begin
      dout_next = 20'h0_0000;
    end
  end

  // Output register adds one pipeline stage ahead of the first sync group.
  always_ff @(posedge aclk)
  begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    rd_reg <= rd_next;
    dout_reg <= dout_next;
    dvalid_reg <= dvalid_next;
  end

  enc_8b10b u_enc_lo
  (
    .byte_in(a_byte),
    .k_in(a_k),
    .rd_in(a_rd),
    .code_out(a_code),
    .rd_out(a_rd_out)
  );

  enc_8b10b u_enc_hi
  (
    .byte_in(b_byte),
    .k_in(b_k),
    .rd_in(b_rd),
    .code_out(b_code),
    .rd_out(b_rd_out)
  );

  always_comb
  begin
    s_axi_awready = awready_reg;
    s_axi_wready = wready_reg;
    s_axi_bvalid = bvalid_reg;
    s_axi_bresp = bresp_reg;
    s_axi_arready = arready_reg;
    s_axi_rvalid = rvalid_reg;
    s_axi_rresp = rresp_reg;
    s_axi_rdata = rdata_reg;
    tx_dataout = dout_reg;
    tx_dataout_valid = dvalid_reg;
    tx_phase_comp_fifo_error = err_reg;
  end
endmodule
`default_nettype wire

// ==== verilog/tx_pcs_regs.svh ====
// Register offsets, field positions, reset values and counts of the TX PCS.
`ifndef TX_PCS_REGS_SVH
`define TX_PCS_REGS_SVH
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define CTRL_DOUBLE_BIT 0
`define CTRL_SER_BIT 1
`define CTRL_ENC_BIT 2
`define CTRL_HILAT_BIT 3
`define CTRL_LLPCS_BIT 4
`define CTRL_RESET 5'h04
`define STAT_ERR_BIT 0
`define STAT_SYNC_BIT 1
`define STAT_LEVEL_LSB 4
`define LANE_W 13
`define LANE_CTRL_BIT 10
`define LANE_FORCE_BIT 11
`define LANE_DVAL_BIT 12
`define FIFO_DEPTH_LOW 4'h4
`define FIFO_DEPTH_HIGH 4'h8
`define FIFO_START_LOW 4'h2
`define FIFO_START_HIGH 4'h4
`define SYNC_GROUPS 2'h3
`define K28_5 8'hbc
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ==== verilog/tx_pcs_pkg.sv ====
// Types shared by the TX PCS modules.
package tx_pcs_pkg;
  typedef enum logic [1:0] {ENC_RESET, ENC_SYNC, ENC_RUN} enc_state_t;
  typedef logic [51:0] word_t;
  typedef logic [3:0] level_t;
endpackage

// ==== verilog/enc_8b10b.sv ====
// One 8b/10b encoder lane with running disparity in and out.
`timescale 1ns/1ps
`default_nettype none
module enc_8b10b
(
  input wire logic [7:0] byte_in,
  input wire logic k_in,
  input wire logic rd_in,
  output logic [9:0] code_out,
  output logic rd_out
);
  logic [5:0] six;
  logic [3:0] four;
  logic rd_mid;
  logic six_bal;
  logic four_bal;
  logic alt7;
  logic flip;
  logic [4:0] x;
  logic [2:0] y;

  always_comb
  begin
    x = byte_in[4:0];
    y = byte_in[7:5];
    unique case (x)
      5'h00: six = 6'b100111;
      5'h01: six = 6'b011101;
      5'h02: six = 6'b101101;
      5'h03: six = 6'b110001;
      5'h04: six = 6'b110101;
      5'h05: six = 6'b101001;
      5'h06: six = 6'b011001;
      5'h07: six = 6'b111000;
      5'h08: six = 6'b111001;
      5'h09: six = 6'b100101;
      5'h0a: six = 6'b010101;
      5'h0b: six = 6'b110100;
      5'h0c: six = 6'b001101;
      5'h0d: six = 6'b101100;
      5'h0e: six = 6'b011100;
      5'h0f: six = 6'b010111;
      5'h10: six = 6'b011011;
      5'h11: six = 6'b100011;
      5'h12: six = 6'b010011;
      5'h13: six = 6'b110010;
      5'h14: six = 6'b001011;
      5'h15: six = 6'b101010;
      5'h16: six = 6'b011010;
      5'h17: six = 6'b111010;
      5'h18: six = 6'b110011;
      5'h19: six = 6'b100110;
      5'h1a: six = 6'b010110;
      5'h1b: six = 6'b110110;
      5'h1c: six = k_in ? 6'b001111 : 6'b001110;
      5'h1d: six = 6'b101110;
      5'h1e: six = 6'b011110;
      5'h1f: six = 6'b101011;
    endcase
    six_bal = ($countones(six) == 3);
    if (rd_in && (!six_bal || x == 5'h07))
    begin
      six = ~six;
    end
    rd_mid = six_bal ? rd_in : !rd_in;
    alt7 = k_in || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
      (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e));
    unique case (y)
      3'h0: four = 4'b1011;
      3'h1: four = 4'b1001;
      3'h2: four = 4'b0101;
      3'h3: four = 4'b1100;
      3'h4: four = 4'b1101;
      3'h5: four = 4'b1010;
      3'h6: four = 4'b0110;
      3'h7: four = alt7 ? 4'b0111 : 4'b1110;
    endcase
    four_bal = ($countones(four) == 2);
    if (k_in && four_bal && y != 3'h3)
    begin
      flip = !rd_mid;
    end
    else
    begin
      flip = rd_mid && (!four_bal || y == 3'h3);
    end
    if (flip)
    begin
      four = ~four;
    end
    rd_out = four_bal ? rd_mid : !rd_mid;
    code_out = {four[0], four[1], four[2], four[3],
      six[0], six[1], six[2], six[3], six[4], six[5]};
  end
endmodule
`default_nettype wire

// ==== verilog/tx_phase_fifo.sv ====
// Phase compensation FIFO with four- or eight-word depth.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pcs_regs.svh"
module tx_phase_fifo
(
  input wire logic aclk,
  input wire logic clear,
  input wire logic high_latency,
  input wire logic wr_en,
  input wire tx_pcs_pkg::word_t wr_data,
  input wire logic rd_en,
  output tx_pcs_pkg::word_t rd_data,
  output tx_pcs_pkg::level_t level,
  output logic full,
  output logic empty
);
  import tx_pcs_pkg::*;
  word_t mem [0:7];
  logic [2:0] wr_ptr_reg;
  logic [2:0] wr_ptr_next;
  logic [2:0] rd_ptr_reg;
  logic [2:0] rd_ptr_next;
  level_t level_reg;
  level_t level_next;
  level_t depth;
  logic do_wr;
  logic do_rd;

  always_comb
  begin
    depth = high_latency ? `FIFO_DEPTH_HIGH : `FIFO_DEPTH_LOW;
    full = (level_reg == depth);
    empty = (level_reg == 4'h0);
    do_rd = rd_en && !empty;
    do_wr = wr_en && (!full || do_rd);
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    level_next = level_reg;
    if (do_wr)
    begin
      wr_ptr_next = (4'(wr_ptr_reg) == depth - 4'h1) ? 3'h0 : wr_ptr_reg + 3'h1;
    end
    if (do_rd)
    begin
      rd_ptr_next = (4'(rd_ptr_reg) == depth - 4'h1) ? 3'h0 : rd_ptr_reg + 3'h1;
    end
    if (do_wr && !do_rd)
    begin
      level_next = level_reg + 4'h1;
    end
    else if (do_rd && !do_wr)
    begin
      level_next = level_reg - 4'h1;
    end
    if (clear)
    begin
      wr_ptr_next = 3'h0;
      rd_ptr_next = 3'h0;
      level_next = 4'h0;
    end
    rd_data = mem[rd_ptr_reg];
    level = level_reg;
  end

  always_ff @(posedge aclk)
  begin
    wr_ptr_reg <= wr_ptr_next;
    rd_ptr_reg <= rd_ptr_next;
    level_reg <= level_next;
    if (do_wr && !clear)
    begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tx_pcs_channel_sva.sv ====
// Assertions and covers on the transmit PCS channel ports.
`timescale 1ns/1ps
`default_nettype none
module tx_pcs_channel_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_digitalreset,
  input wire logic [19:0] tx_dataout,
  input wire logic tx_dataout_valid,
  input wire logic tx_phase_comp_fifo_error
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence in_rst;
    $past(tx_digitalreset) && $past(tx_digitalreset, 2);
  endsequence
  rst_low_a:
    assert property (in_rst and tx_dataout_valid |->
      tx_dataout[9:0] == 10'h17c) else $error("bad reset group");
  rst_high_a:
    assert property (in_rst and tx_dataout_valid |->
      tx_dataout[19:10] inside {10'h000, 10'h283})
      else $error("bad reset high group");
  ser_rst_a:
    assert property (in_rst and !tx_dataout_valid |->
      tx_dataout == {10'h000, 10'h000}) else $error("serializer not reset");
  err_clear_a:
    assert property ($past(tx_digitalreset) |-> !tx_phase_comp_fifo_error)
      else $error("error flag not cleared");
  err_hold_a:
    assert property (tx_phase_comp_fifo_error && !tx_digitalreset &&
      s_axi_awready && !s_axi_wvalid |=> tx_phase_comp_fifo_error)
      else $error("error flag dropped");
  sync_first_a:
    assert property ($fell(tx_digitalreset) && tx_dataout_valid &&
      tx_dataout[19:10] == 10'h000 |-> ##[1:5]
      (tx_dataout_valid && tx_dataout[9:0] == 10'h283))
      else $error("no sync sequence");
  b_once_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
  r_once_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
  b_busy_a:
    assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready))
      else $error("address accepted while a write was pending");
  cover property (tx_phase_comp_fifo_error);
  cover property ($fell(tx_digitalreset) && tx_dataout_valid);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind tx_pcs_channel tx_pcs_channel_sva tx_pcs_channel_sva_inst
(
  .aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .tx_digitalreset,
  .tx_dataout, .tx_dataout_valid, .tx_phase_comp_fifo_error
);
`default_nettype wire

// ==== tb/fabric_source.sv ====
// Fabric word source that feeds the phase compensation FIFO.
`timescale 1ns/1ps
`default_nettype none
module fabric_source
(
  input wire logic aclk,
  input wire logic go,
  input wire logic gap,
  input wire logic coded,
  output logic wr_en,
  output logic [39:0] data,
  output logic [3:0] ctrl,
  output logic [3:0] force_d,
  output logic [3:0] dval
);
  logic [16:0] lf = 17'h1_2317;
  logic ph = 1'b0;
  function automatic logic [16:0] step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  initial {wr_en, data, ctrl, force_d, dval} = '0;
  always @(posedge aclk)
  begin
    ph <= go && gap && !ph;
    wr_en <= go && !ph;
    if (go && !ph)
    begin
      for (int i = 0; i < 4; i++)
      begin
        lf = step(step(step(lf)));
        data[10*i +: 10] <= coded ? {2'b00, lf[11] ? 8'hb5 : 8'hbc} : lf[9:0];
        ctrl[i] <= lf[10] & !lf[11];
        force_d[i] <= coded & lf[12] & lf[13];
        dval[i] <= lf[14];
      end
    end
    else
      data <= ~data;
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the transmit PCS channel.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic tx_digitalreset = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_wr_en, tx_dataout_valid, tx_phase_comp_fifo_error;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic [39:0] tx_datain;
  logic [3:0] tx_ctrlenable, tx_forcedisp, tx_dispval;
  logic [19:0] tx_dataout, rpat;
  logic go = 1'b0, gap = 1'b0, cmp_on = 1'b0, rst_d = 1'b1, neg = 1'b0;
  logic enc_on;
  logic [7:0] mode = 8'h04;
  logic [9:0] lo, hi;
  logic [8:0] tbl [8] = '{9'h000, 9'h001, 9'h102, 9'h103, 9'h014, 9'h004,
    9'h005, 9'h00c};
  int hunt = 3, n_fail = 0, checks = 0, cyc = 0;
  logic [19:0] q [$];
  assign enc_on = mode[2] && !mode[4];
  assign rpat = {mode[0] ? 10'h283 : 10'h000, 10'h17c};
  always #2 aclk = ~aclk;
  tx_pcs_channel tx_pcs_channel_inst
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_digitalreset, .tx_wr_en, .tx_datain, .tx_ctrlenable, .tx_forcedisp,
    .tx_dispval, .tx_dataout, .tx_dataout_valid, .tx_phase_comp_fifo_error
  );
  fabric_source fabric_source_inst
  (
    .aclk, .go, .gap, .coded(enc_on), .wr_en(tx_wr_en), .data(tx_datain),
    .ctrl(tx_ctrlenable), .force_d(tx_forcedisp), .dval(tx_dispval)
  );
  task automatic chk_grp(input logic [19:0] g, input logic [19:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t group %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [9:0] enc(input logic [7:0] b, input logic k,
    input logic f, input logic v);
    logic m;
    m = f ? v : neg;
    if (b == 8'hbc && k)
    begin
      neg = !m;
      return m ? 10'h17c : 10'h283;
    end
    neg = m;
    return b == 8'hbc ? 10'h15c : 10'h155;
  endfunction
  task automatic push;
    logic [39:0] d;
    d = tx_datain;
    if (enc_on)
    begin
      lo = enc(d[7:0], tx_ctrlenable[0], tx_forcedisp[0], tx_dispval[0]);
      hi = mode[0] ? enc(d[17:10], tx_ctrlenable[1], tx_forcedisp[1],
        tx_dispval[1]) : 10'h000;
      q.push_back({hi, lo});
    end
    else if (mode[1])
    begin
      q.push_back(mode[0] ? d[19:0] : {10'h000, d[9:0]});
      q.push_back(mode[0] ? d[39:20] : {10'h000, d[19:10]});
    end
    else
      q.push_back(mode[0] ? d[19:0] : {10'h000, d[9:0]});
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  always @(posedge aclk)
  begin
    rst_d <= tx_digitalreset;
    if (tx_wr_en && cmp_on)
      push();
    if (tx_dataout_valid && cmp_on)
    begin
      if (rst_d || hunt >= 4)
      begin
        chk_grp(tx_dataout, rpat);
        if (!rst_d)
          hunt <= (hunt == 6) ? 3 : hunt + 1;
      end
      else if (hunt == 0)
        hunt <= tx_dataout[9:0] == 10'h17c ? 1 : 0;
      else if (hunt == 1 && tx_dataout[9:0] != 10'h17c)
      begin
        chk_grp(tx_dataout, {10'h000, 10'h283});
        hunt <= 2;
      end
      else if (hunt == 2)
      begin
        chk_grp(tx_dataout, {10'h000, 10'h17c});
        hunt <= 3;
      end
      else if (hunt != 1)
      begin
        hunt <= 3;
        if (q.size() == 0)
          chk_reg(32'h1, 32'h0);
        else
          chk_grp(tx_dataout, q.pop_front());
      end
    end
  end
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run(input logic [7:0] c, input logic g);
    tx_digitalreset <= 1'b1;
    axw(4'h0, {24'h0, c});
    chk_reg({30'h0, rr}, 32'h0);
    mode <= c;
    neg = c[0];
    hunt = (!c[2] || c[4]) ? 3 : (c[0] ? 4 : 0);
    repeat (2) @(posedge aclk);
    cmp_on <= 1'b1;
    repeat (4) @(posedge aclk);
    tx_digitalreset <= 1'b0;
    go <= 1'b1;
    gap <= g;
    repeat (300) @(posedge aclk);
    chk_reg({31'h0, tx_phase_comp_fifo_error}, 32'h0);
    go <= 1'b0;
    repeat (30) @(posedge aclk);
    chk_reg(32'(q.size()), 32'h0);
    chk_reg({31'h0, tx_phase_comp_fifo_error}, 32'h1);
    cmp_on <= 1'b0;
  endtask
  task automatic ovf(input logic [7:0] c, input logic [3:0] depth);
    tx_digitalreset <= 1'b1;
    axw(4'h0, {24'h0, c});
    repeat (2) @(posedge aclk);
    tx_digitalreset <= 1'b0;
    go <= 1'b1;
    gap <= 1'b0;
    repeat (60) @(posedge aclk);
    axr(4'h4);
    chk_reg(rd & 32'hf1, {24'h0, depth, 4'h1});
    tx_digitalreset <= 1'b1;
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_reg({31'h0, tx_phase_comp_fifo_error}, 32'h0);
  endtask
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(4'h0);
    chk_reg(rd, 32'h4);
    axr(4'h8);
    chk_reg({rd[29:0], rr}, 32'h2);
    axw(4'hc, 32'hffff_ffff);
    chk_reg({30'h0, rr}, 32'h2);
    foreach (tbl[i])
      run(tbl[i][7:0], tbl[i][8]);
    ovf(8'h02, 4'h4);
    ovf(8'h0a, 4'h8);
    results();
  end
endmodule
`default_nettype wire
